// file: src/aohr_pkg.sv
package aohr_pkg;
  // ---------------------------------------------------------------------------
  // sample format
  // ---------------------------------------------------------------------------
  localparam int unsigned SW = 24;
  localparam logic signed [23:0] FS_POS = 24'sh7fffff;
  localparam logic signed [23:0] FS_NEG = -24'sh800000;

  // ---------------------------------------------------------------------------
  // register map (byte addresses)
  // ---------------------------------------------------------------------------
  localparam logic [7:0] R_BUS1_SEL   = 8'h00; // [2:0] left src, [6:4] right src
  localparam logic [7:0] R_BUS1_ATT   = 8'h04; // [5:0] attenuation in dB
  localparam logic [7:0] R_BUS2_SEL   = 8'h08;
  localparam logic [7:0] R_BUS2_ATT   = 8'h0c;
  localparam logic [7:0] R_DIG_FMT    = 8'h10; // [0] 1 = professional
  localparam logic [7:0] R_HP_CTRL    = 8'h14; // write pulses, see below
  localparam logic [7:0] R_HP_STATUS  = 8'h18; // read only
  localparam logic [7:0] R_HP_SLOT0   = 8'h40; // 20 slot words, read only
  localparam int unsigned SEL_L_LSB = 0;
  localparam int unsigned SEL_R_LSB = 4;
  localparam int unsigned ATT_MAX   = 40;
  localparam int unsigned FMT_PRO_BIT = 0;
  // hp control bits
  localparam int unsigned HC_TURN_UP = 0;
  localparam int unsigned HC_TURN_DN = 1;
  localparam int unsigned HC_SETUP   = 2;
  localparam int unsigned HC_CONFIRM = 3;
  localparam int unsigned HC_FINISH  = 4;
  localparam int unsigned HC_CANCEL  = 5;

  // ---------------------------------------------------------------------------
  // output bus sources
  // ---------------------------------------------------------------------------
  typedef enum logic [2:0] {
    AOHR_SRC_IN1  = 3'h0,
    AOHR_SRC_IN2  = 3'h1,
    AOHR_SRC_TRA  = 3'h2,
    AOHR_SRC_TRB  = 3'h3,
    AOHR_SRC_INS  = 3'h4,
    AOHR_SRC_TRS  = 3'h5
  } aohr_src_e;
  localparam logic [2:0] SRC_LAST = 3'h5;

  // ---------------------------------------------------------------------------
  // headphone sources
  // ---------------------------------------------------------------------------
  typedef enum logic [3:0] {
    AOHR_HP_IN_PAIR  = 4'h0,
    AOHR_HP_TR_PAIR  = 4'h1,
    AOHR_HP_MON_PAIR = 4'h2,
    AOHR_HP_IN1_SOLO = 4'h3,
    AOHR_HP_IN2_SOLO = 4'h4,
    AOHR_HP_TRA_SOLO = 4'h5,
    AOHR_HP_TRB_SOLO = 4'h6,
    AOHR_HP_MNA_SOLO = 4'h7,
    AOHR_HP_MNB_SOLO = 4'h8,
    AOHR_HP_IN_MS    = 4'h9,
    AOHR_HP_TR_MS    = 4'ha,
    AOHR_HP_MON_MS   = 4'hb,
    AOHR_HP_IN_SUM   = 4'hc,
    AOHR_HP_TR_SUM   = 4'hd
  } aohr_hp_e;
  localparam logic [3:0] HP_LAST = 4'hd;
  localparam int unsigned NSLOT   = 20;
  localparam int unsigned NPRESET = 5;
  localparam logic [4:0] NSLOT_M1 = 5'd19;
  localparam logic [4:0] NPRESET_M1 = 5'd4;

  // slot setup menu states
  typedef enum logic [1:0] {
    AOHR_ST_RUN   = 2'b01,
    AOHR_ST_SETUP = 2'b10
  } aohr_menu_e;
endpackage : aohr_pkg

// file: src/aohr_router.sv
// What this block does
// - two buses, left and right chosen separately
// - six sources: inputs, tracks, input sum, track sum
// - input source passes regardless of transport state
// - track source: assignment, or playback while playing
// - analog bus 0..40 dB attenuation, both sides
// - analog attenuation also scales tape output
// - digital bus selection held independently
// - digital format pro/consumer, copy bit clear
// - digital bus full scale, 1 dB steps to 40
// - headphone selection independent of bus routing
// - monitor plays medium readback, latency allowed
// - monitor only from samples written to medium
// - twenty user slots plus five presets
// - pair: first member left, second right
// - solo sends one signal to both ears
// - hp tracks switch to playback audio
// - monitor selections silent unless playing back
// - mid-side selections decode to left/right
// - summed mono sends sum to both ears
// - setup starts slot one, turn, confirm, finish, cancel
// - finish at slot one leaves single track pair
// - turning steps active source through list
// - mid from first, side from second, equal spread
`timescale 1ns/10ps
module aohr_router (
  input  wire logic                 ref_clk,
  input  wire logic                 reset,
  // classic wishbone slave
  input  wire logic                 wb_cyc_i,
  input  wire logic                 wb_stb_i,
  input  wire logic                 wb_we_i,
  input  wire logic [7:0]           wb_adr_i,
  input  wire logic [3:0]           wb_sel_i,
  input  wire logic [31:0]          wb_dat_i,
  output logic      [31:0]          wb_dat_o,
  output logic                      wb_ack_o,
  // audio, one sample per sample_stb
  input  wire logic                 sample_stb,
  input  wire logic                 playing,
  input  wire logic signed [23:0]   in1,
  input  wire logic signed [23:0]   in2,
  input  wire logic signed [23:0]   trk_a,
  input  wire logic signed [23:0]   trk_b,
  input  wire logic signed [23:0]   play_a,
  input  wire logic signed [23:0]   play_b,
  input  wire logic signed [23:0]   mon_a,
  input  wire logic signed [23:0]   mon_b,
  output logic signed [23:0]        bus1_l,
  output logic signed [23:0]        bus1_r,
  output logic [5:0]                tape_att,
  output logic signed [23:0]        bus2_l,
  output logic signed [23:0]        bus2_r,
  output logic                      dig_pro,
  output logic                      dig_copy_bit,
  output logic signed [23:0]        hp_l,
  output logic signed [23:0]        hp_r
);
  import aohr_pkg::*;

  // ---------------------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------------------
  function automatic logic signed [23:0] sat_add(input logic signed [23:0] a,
                                                 input logic signed [23:0] b);
    logic signed [24:0] s;
    s = {a[23], a} + {b[23], b};
    sat_add = (s > 25'sh07fffff) ? FS_POS : (s < -25'sh0800000) ? FS_NEG : s[23:0];
  endfunction : sat_add

  // 1 dB steps: 6 dB by shift, remainder by a small gain table (q8)
  function automatic logic signed [23:0] atten(input logic signed [23:0] x,
                                               input logic [5:0] db);
    logic signed [23:0] sh;
    logic        [8:0]  g;
    logic signed [33:0] p;
    sh = x >>> (db / 6'd6);
    case (db % 6'd6)
      6'd0:    g = 9'd256;
      6'd1:    g = 9'd228;
      6'd2:    g = 9'd203;
      6'd3:    g = 9'd181;
      6'd4:    g = 9'd162;
      default: g = 9'd144;
    endcase
    p = sh * $signed({1'b0, g});
    atten = p[31:8];
  endfunction : atten

  // playback overrides the assignment on the track paths
  logic signed [23:0] ta_eff;
  logic signed [23:0] tb_eff;
  assign ta_eff = playing ? play_a : trk_a;
  assign tb_eff = playing ? play_b : trk_b;

  function automatic logic signed [23:0] pick(input logic [2:0] s,
                                              input logic signed [23:0] i1,
                                              input logic signed [23:0] i2,
                                              input logic signed [23:0] a,
                                              input logic signed [23:0] b);
    case (s)
      AOHR_SRC_IN1: pick = i1;
      AOHR_SRC_IN2: pick = i2;
      AOHR_SRC_TRA: pick = a;
      AOHR_SRC_TRB: pick = b;
      AOHR_SRC_INS: pick = sat_add(i1, i2);
      default:      pick = sat_add(a, b);
    endcase
  endfunction : pick

  // ---------------------------------------------------------------------------
  // configuration registers
  // ---------------------------------------------------------------------------
  logic [2:0] b1_sl;
  logic [2:0] b1_sr;
  logic [5:0] b1_att;
  logic [2:0] b2_sl;
  logic [2:0] b2_sr;
  logic [5:0] b2_att;
  logic       fmt_pro;
  logic       wr;

  assign wr = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_sel_i[0];

  // out of range source codes are refused so selections stay legal; attenuation codes above 40 clamp to 40
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      b1_sl   <= 3'h0;
      b1_sr   <= 3'h1;
      b1_att  <= 6'h00;
      b2_sl   <= 3'h0;
      b2_sr   <= 3'h1;
      b2_att  <= 6'h00;
      fmt_pro <= 1'b1;
    end else if (wr) begin
      if (wb_adr_i == R_BUS1_SEL) begin
        if (wb_dat_i[2:0] <= SRC_LAST) b1_sl <= wb_dat_i[2:0];
        if (wb_dat_i[6:4] <= SRC_LAST) b1_sr <= wb_dat_i[6:4];
      end else if (wb_adr_i == R_BUS1_ATT) begin
        b1_att <= (wb_dat_i[5:0] > 6'd40) ? 6'd40 : wb_dat_i[5:0];
      end else if (wb_adr_i == R_BUS2_SEL) begin
        if (wb_dat_i[2:0] <= SRC_LAST) b2_sl <= wb_dat_i[2:0];
        if (wb_dat_i[6:4] <= SRC_LAST) b2_sr <= wb_dat_i[6:4];
      end else if (wb_adr_i == R_BUS2_ATT) begin
        b2_att <= (wb_dat_i[5:0] > 6'd40) ? 6'd40 : wb_dat_i[5:0];
      end else if (wb_adr_i == R_DIG_FMT) begin
        fmt_pro <= wb_dat_i[FMT_PRO_BIT];
      end
    end
  end

  // ---------------------------------------------------------------------------
  // headphone list and setup menu
  // ---------------------------------------------------------------------------
  logic [3:0] slot [NSLOT];
  logic [4:0] slot_cnt;   // used entries, 0 = presets active, or the single track pair once presets_on clears
  logic [3:0] preset [NPRESET];
  logic       presets_on;
  logic [4:0] act_idx;
  logic [4:0] edit_idx;
  logic [3:0] edit_src;
  aohr_menu_e menu;
  logic [5:0] hc;
  logic [4:0] list_last;
  logic [3:0] act_src;

  assign hc = (wr && wb_adr_i == R_HP_CTRL) ? wb_dat_i[5:0] : 6'h00;
  assign list_last = (slot_cnt != 5'd0) ? slot_cnt - 5'd1 : NPRESET_M1;

  assign preset[0] = AOHR_HP_IN_PAIR;
  assign preset[1] = AOHR_HP_TR_PAIR;
  assign preset[2] = AOHR_HP_MON_PAIR;
  assign preset[3] = AOHR_HP_IN_MS;
  assign preset[4] = AOHR_HP_TR_SUM;

  // the list in force: user slots if any, else presets, else one track pair
  always_comb begin
    if (slot_cnt != 5'd0)
      act_src = slot[act_idx];
    else if (presets_on)
      act_src = preset[act_idx[2:0]];
    else
      act_src = AOHR_HP_TR_PAIR;
  end

  // menu sequencing and active-source stepping
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      menu       <= AOHR_ST_RUN;
      act_idx    <= 5'd0;
      edit_idx   <= 5'd0;
      edit_src   <= 4'h0;
      slot_cnt   <= 5'd0;
      presets_on <= 1'b1;
    end else begin
      case (menu)
        AOHR_ST_RUN: begin
          if (hc[HC_SETUP]) begin
            menu     <= AOHR_ST_SETUP;
            edit_idx <= 5'd0;
            edit_src <= 4'h0;
          end else if (hc[HC_TURN_UP] && presets_on | (slot_cnt != 5'd0)) begin
            act_idx <= (act_idx >= list_last) ? 5'd0 : act_idx + 5'd1;
          end else if (hc[HC_TURN_DN] && presets_on | (slot_cnt != 5'd0)) begin
            act_idx <= (act_idx == 5'd0) ? list_last : act_idx - 5'd1;
          end
        end
        AOHR_ST_SETUP: begin
          if (hc[HC_CANCEL]) begin
            menu <= AOHR_ST_RUN;
          end else if (hc[HC_FINISH]) begin
            menu    <= AOHR_ST_RUN;
            act_idx <= 5'd0;
            if (edit_idx == 5'd0) begin
              slot_cnt   <= 5'd0;
              presets_on <= 1'b0;
            end else begin
              slot_cnt <= edit_idx;
            end
          end else if (hc[HC_CONFIRM]) begin
            if (edit_idx == NSLOT_M1) begin
              menu     <= AOHR_ST_RUN;
              slot_cnt <= 5'd20;
              act_idx  <= 5'd0;
            end else begin
              edit_idx <= edit_idx + 5'd1;
            end
          end else if (hc[HC_TURN_UP]) begin
            edit_src <= (edit_src == HP_LAST) ? 4'h0 : edit_src + 4'h1;
          end else if (hc[HC_TURN_DN]) begin
            edit_src <= (edit_src == 4'h0) ? HP_LAST : edit_src - 4'h1;
          end
        end
        default: menu <= AOHR_ST_RUN;
      endcase
    end
  end

  // slot storage; each entry is written on confirm and stays written even if setup is cancelled
  for (genvar i = 0; i < NSLOT; i++) begin : g_slot
    always_ff @(posedge ref_clk) begin
      if (reset)
        slot[i] <= 4'h0;
      else if (menu == AOHR_ST_SETUP && edit_idx == 5'(i) && hc[HC_CONFIRM])
        slot[i] <= edit_src;
    end
  end

  // ---------------------------------------------------------------------------
  // audio datapath, updated on the sample strobe
  // ---------------------------------------------------------------------------
  logic signed [23:0] next_hp_l;
  logic signed [23:0] next_hp_r;
  logic signed [23:0] ma;
  logic signed [23:0] mb;
  logic signed [23:0] ms_m;
  logic signed [23:0] ms_s;

  // monitor words come only from medium readback, and only while playing
  assign ma = playing ? mon_a : 24'sh000000;
  assign mb = playing ? mon_b : 24'sh000000;

  always_comb begin
    ms_m      = 24'sh000000;
    ms_s      = 24'sh000000;
    next_hp_l = 24'sh000000;
    next_hp_r = 24'sh000000;
    case (act_src)
      AOHR_HP_IN_PAIR:  begin next_hp_l = in1;    next_hp_r = in2;    end
      AOHR_HP_TR_PAIR:  begin next_hp_l = ta_eff; next_hp_r = tb_eff; end
      AOHR_HP_MON_PAIR: begin next_hp_l = ma;     next_hp_r = mb;     end
      AOHR_HP_IN1_SOLO: begin next_hp_l = in1;    next_hp_r = in1;    end
      AOHR_HP_IN2_SOLO: begin next_hp_l = in2;    next_hp_r = in2;    end
      AOHR_HP_TRA_SOLO: begin next_hp_l = ta_eff; next_hp_r = ta_eff; end
      AOHR_HP_TRB_SOLO: begin next_hp_l = tb_eff; next_hp_r = tb_eff; end
      AOHR_HP_MNA_SOLO: begin next_hp_l = ma;     next_hp_r = ma;     end
      AOHR_HP_MNB_SOLO: begin next_hp_l = mb;     next_hp_r = mb;     end
      // equal spread: halve M and S first so the decode keeps headroom
      AOHR_HP_IN_MS:    begin ms_m = in1 >>> 1;    ms_s = in2 >>> 1;    end
      AOHR_HP_TR_MS:    begin ms_m = ta_eff >>> 1; ms_s = tb_eff >>> 1; end
      AOHR_HP_MON_MS:   begin ms_m = ma >>> 1;     ms_s = mb >>> 1;     end
      AOHR_HP_IN_SUM:   begin next_hp_l = sat_add(in1, in2); next_hp_r = next_hp_l; end
      default: begin
        next_hp_l = sat_add(ta_eff, tb_eff);
        next_hp_r = sat_add(ta_eff, tb_eff);
      end
    endcase
    // decode step shared by the three mid-side selections
    if (act_src inside {AOHR_HP_IN_MS, AOHR_HP_TR_MS, AOHR_HP_MON_MS}) begin
      next_hp_l = sat_add(ms_m, ms_s);
      next_hp_r = sat_add(ms_m, -ms_s);
    end
  end

  // headphone path never reads the bus selections
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      hp_l <= 24'sh000000;
      hp_r <= 24'sh000000;
    end else if (sample_stb) begin
      hp_l <= next_hp_l;
      hp_r <= next_hp_r;
    end
  end

  // output buses
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      bus1_l <= 24'sh000000;
      bus1_r <= 24'sh000000;
      bus2_l <= 24'sh000000;
      bus2_r <= 24'sh000000;
    end else if (sample_stb) begin
      bus1_l <= atten(pick(b1_sl, in1, in2, ta_eff, tb_eff), b1_att);
      bus1_r <= atten(pick(b1_sr, in1, in2, ta_eff, tb_eff), b1_att);
      bus2_l <= atten(pick(b2_sl, in1, in2, ta_eff, tb_eff), b2_att);
      bus2_r <= atten(pick(b2_sr, in1, in2, ta_eff, tb_eff), b2_att);
    end
  end

  // tape out follows the analog bus setting; status bits for the encoder
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      tape_att     <= 6'h00;
      dig_pro      <= 1'b1;
      dig_copy_bit <= 1'b0;
    end else begin
      tape_att     <= b1_att;
      dig_pro      <= fmt_pro;
      dig_copy_bit <= 1'b0;
    end
  end

  // ---------------------------------------------------------------------------
  // wishbone read and acknowledge, one wait state free
  // ---------------------------------------------------------------------------
  logic [4:0] slot_rd_idx;
  assign slot_rd_idx = 5'((wb_adr_i - R_HP_SLOT0) >> 2);

  always_ff @(posedge ref_clk) begin
    if (reset)
      wb_ack_o <= 1'b0;
    else
      wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
  end

  // read data registered in the same edge that raises the acknowledge
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      wb_dat_o <= 32'h00000000;
    end else if (wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_we_i) begin
      if (wb_adr_i == R_BUS1_SEL)
        wb_dat_o <= {25'h0, b1_sr, 1'b0, b1_sl};
      else if (wb_adr_i == R_BUS1_ATT)
        wb_dat_o <= {26'h0, b1_att};
      else if (wb_adr_i == R_BUS2_SEL)
        wb_dat_o <= {25'h0, b2_sr, 1'b0, b2_sl};
      else if (wb_adr_i == R_BUS2_ATT)
        wb_dat_o <= {26'h0, b2_att};
      else if (wb_adr_i == R_DIG_FMT)
        wb_dat_o <= {31'h0, fmt_pro};
      else if (wb_adr_i == R_HP_STATUS)
        wb_dat_o <= {11'h0, presets_on, 2'h0, menu, 2'h0, slot_cnt, edit_idx, act_src};
      else if (wb_adr_i >= R_HP_SLOT0 && slot_rd_idx < 5'd20 && wb_adr_i[1:0] == 2'b00)
        wb_dat_o <= {28'h0, slot[slot_rd_idx]};
      else
        wb_dat_o <= 32'h00000000;
    end
  end

  // ---------------------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------------------
  a_copy_bit_clear: assert property (@(posedge ref_clk) disable iff (reset)
    !dig_copy_bit) else $error("copy bit set");
  a_att_range: assert property (@(posedge ref_clk) disable iff (reset)
    b1_att <= 6'd40 && b2_att <= 6'd40) else $error("attenuation out of range");
  a_tape_follows: assert property (@(posedge ref_clk) disable iff (reset)
    1'b1 |=> tape_att == $past(b1_att)) else $error("tape att mismatch");
  a_mon_silent: assert property (@(posedge ref_clk) disable iff (reset)
    sample_stb && !playing && act_src inside {AOHR_HP_MON_PAIR, AOHR_HP_MNA_SOLO,
    AOHR_HP_MNB_SOLO, AOHR_HP_MON_MS} |=> hp_l == 24'sh0 && hp_r == 24'sh0)
    else $error("monitor not silent");
  a_solo_both: assert property (@(posedge ref_clk) disable iff (reset)
    sample_stb && act_src == AOHR_HP_IN1_SOLO |=> hp_l == hp_r && hp_l == $past(in1))
    else $error("solo mismatch");
  a_pair_order: assert property (@(posedge ref_clk) disable iff (reset)
    sample_stb && act_src == AOHR_HP_IN_PAIR |=> hp_l == $past(in1) && hp_r == $past(in2))
    else $error("pair order wrong");
  a_finish_first: assert property (@(posedge ref_clk) disable iff (reset)
    menu == AOHR_ST_SETUP && hc[HC_FINISH] && !hc[HC_CANCEL] && edit_idx == 5'd0
    |=> act_src == AOHR_HP_TR_PAIR && !presets_on) else $error("finish at slot one");
  a_cancel_exit: assert property (@(posedge ref_clk) disable iff (reset)
    menu == AOHR_ST_SETUP && hc[HC_CANCEL] |=> menu == AOHR_ST_RUN && $stable(slot_cnt))
    else $error("cancel did not exit");
  a_setup_start: assert property (@(posedge ref_clk) disable iff (reset)
    menu == AOHR_ST_RUN && hc[HC_SETUP] |=> menu == AOHR_ST_SETUP && edit_idx == 5'd0)
    else $error("setup not at slot one");
  c_setup_done: cover property (@(posedge ref_clk) menu == AOHR_ST_SETUP && hc[HC_FINISH]);
  c_turn_step: cover property (@(posedge ref_clk) menu == AOHR_ST_RUN && hc[HC_TURN_UP]);
  c_playback_ms: cover property (@(posedge ref_clk) playing && act_src == AOHR_HP_TR_MS);
endmodule : aohr_router

// file: verif/aohr_smp_src.sv
`timescale 1ns/10ps
// downstream converter: one sample strobe every eight clocks
module aohr_smp_src (
  input  wire logic ref_clk,
  input  wire logic reset,
  output logic      sample_stb
);
  logic [2:0] div;
  // free-running divider, parked at zero in reset so runs repeat
  always_ff @(posedge ref_clk) begin
    if (reset) div <= 3'h0;
    else div <= div + 3'h1;
  end
  assign sample_stb = (div == 3'h7);
endmodule : aohr_smp_src

// file: verif/tb.sv
`timescale 1ns/10ps
module tb;
  import aohr_pkg::*;
  logic ref_clk = 1'b0, reset = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, playing = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0, rd, dat_o;
  logic ack, sample_stb, dig_pro, copy_bit;
  logic [5:0] tape_att;
  logic signed [23:0] i1 = 24'h7fff00, i2 = 24'h000200, ta = 24'h800100, tk = 24'hff0000;
  logic signed [23:0] pa = 24'h111111, pb = 24'h222222, ma = 24'h333333, mb = 24'h444444;
  logic signed [23:0] b1l, b1r, b2l, b2r, hl, hr;
  int errors = 0, check_count = 0;
  always #5 ref_clk = ~ref_clk;
  aohr_smp_src src (.ref_clk(ref_clk), .reset(reset), .sample_stb(sample_stb));
  aohr_router dut (.ref_clk(ref_clk), .reset(reset), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(dat_o),
    .wb_ack_o(ack), .sample_stb(sample_stb), .playing(playing), .in1(i1), .in2(i2),
    .trk_a(ta), .trk_b(tk), .play_a(pa), .play_b(pb), .mon_a(ma), .mon_b(mb),
    .bus1_l(b1l), .bus1_r(b1r), .tape_att(tape_att), .bus2_l(b2l), .bus2_r(b2r),
    .dig_pro(dig_pro), .dig_copy_bit(copy_bit), .hp_l(hl), .hp_r(hr));
  // ---------------------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------------------
  task automatic give_verdict;
    if (errors == 0 && check_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : give_verdict
  task automatic chk(input string nm, input logic [23:0] exp, input logic [23:0] got);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  // one classic cycle; the master never assumes the slave latency
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge ref_clk);
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wdat <= d;
    do begin @(posedge ref_clk); n++; end while (ack !== 1'b1 && n < 20);
    rd = dat_o;
    cyc <= 1'b0; stb <= 1'b0;
    if (ack !== 1'b1) begin errors++; give_verdict(); end
  endtask : wb
  // two strobes guarantee the outputs reflect the current setup
  task automatic smp;
    int n;
    n = 0;
    repeat (2) do begin @(posedge ref_clk); n++; end while (sample_stb !== 1'b1 && n < 40);
    @(posedge ref_clk);
    if (n >= 40) begin errors++; give_verdict(); end
  endtask : smp
  function automatic logic [23:0] sat(input logic signed [23:0] a, input logic signed [23:0] b);
    logic signed [24:0] s;
    s = a + b;
    if (s > 25'sh07fffff) return 24'h7fffff;
    if (s < -25'sh0800000) return 24'h800000;
    return s[23:0];
  endfunction : sat
  function automatic logic [23:0] exp_src(input logic [2:0] c);
    case (c)
      3'h0: return i1;
      3'h1: return i2;
      3'h2: return playing ? pa : ta;
      3'h3: return playing ? pb : tk;
      3'h4: return sat(i1, i2);
      default: return playing ? sat(pa, pb) : sat(ta, tk);
    endcase
  endfunction : exp_src
  // ---------------------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------------------
  task automatic t_reset;
    chk("dig_pro", 24'h1, dig_pro);
    chk("tape_att", 24'h0, tape_att);
    smp();
    chk("bus1_l", i1, b1l);
    chk("bus1_r", i2, b1r);
  endtask : t_reset
  // bus2 gets the mirror code so a shared selection would show up
  task automatic t_bus;
    for (int p = 0; p < 2; p++) begin
      playing <= p[0];
      for (int c = 0; c < 6; c++) begin
        wb(1'b1, R_BUS1_SEL, {25'h0, 3'(5 - c), 1'b0, 3'(c)});
        wb(1'b1, R_BUS2_SEL, {25'h0, 3'(c), 1'b0, 3'(5 - c)});
        smp();
        chk("bus1_l", exp_src(3'(c)), b1l);
        chk("bus1_r", exp_src(3'(5 - c)), b1r);
        chk("bus2_l", exp_src(3'(5 - c)), b2l);
        chk("bus2_r", exp_src(3'(c)), b2r);
      end
    end
    playing <= 1'b0;
  endtask : t_bus
  // 6 dB is exactly one binary halving on both buses
  task automatic t_att;
    wb(1'b1, R_BUS1_SEL, 32'h10);
    wb(1'b1, R_BUS2_SEL, 32'h10);
    wb(1'b1, R_BUS1_ATT, 32'h6);
    wb(1'b1, R_BUS2_ATT, 32'h6);
    smp();
    chk("bus1_l", i1 >>> 1, b1l);
    chk("bus1_r", i2 >>> 1, b1r);
    chk("bus2_l", i1 >>> 1, b2l);
    chk("tape_att", 24'h6, tape_att);
    wb(1'b1, R_BUS1_ATT, 32'h32);
    smp();
    chk("tape_att", 24'd40, tape_att);
    wb(1'b0, R_BUS1_ATT, 32'h0);
    chk("att_rd", 24'd40, rd[23:0]);
    wb(1'b1, R_BUS1_ATT, 32'h0);
    wb(1'b1, R_BUS2_ATT, 32'h0);
  endtask : t_att
  task automatic t_fmt;
    wb(1'b1, R_DIG_FMT, 32'h0);
    smp();
    chk("dig_pro", 24'h0, dig_pro);
    chk("copy_bit", 24'h0, copy_bit);
    wb(1'b1, R_DIG_FMT, 32'h1);
    smp();
    chk("dig_pro", 24'h1, dig_pro);
    chk("copy_bit", 24'h0, copy_bit);
    wb(1'b0, 8'hf0, 32'h0);
    chk("unmapped", 24'h0, rd[23:0]);
  endtask : t_fmt
  task automatic hp(input int bit_n, input logic [23:0] el, input logic [23:0] er);
    wb(1'b1, R_HP_CTRL, 32'h1 << bit_n);
    smp();
    chk("hp_l", el, hl);
    chk("hp_r", er, hr);
  endtask : hp
  // walks four of the five presets, builds a two-slot list, then the empty list and a cancel
  task automatic t_hp;
    smp();
    chk("hp_l", i1, hl);
    chk("hp_r", i2, hr);
    hp(HC_TURN_UP, ta, tk);
    playing <= 1'b1;
    hp(HC_TURN_UP, ma, mb);
    playing <= 1'b0;
    smp();
    chk("hp_l", 24'h0, hl);
    hp(HC_TURN_UP, (i1 >>> 1) + (i2 >>> 1), (i1 >>> 1) - (i2 >>> 1));
    wb(1'b1, R_HP_CTRL, 32'h1 << HC_SETUP);
    repeat (12) wb(1'b1, R_HP_CTRL, 32'h1 << HC_TURN_UP);
    wb(1'b1, R_HP_CTRL, 32'h1 << HC_CONFIRM);
    repeat (9) wb(1'b1, R_HP_CTRL, 32'h1 << HC_TURN_DN);
    wb(1'b1, R_HP_CTRL, 32'h1 << HC_CONFIRM);
    hp(HC_FINISH, sat(i1, i2), sat(i1, i2));
    hp(HC_TURN_UP, i1, i1);
    hp(HC_TURN_UP, sat(i1, i2), sat(i1, i2));
    wb(1'b1, R_HP_CTRL, 32'h1 << HC_SETUP);
    hp(HC_FINISH, ta, tk);
    playing <= 1'b1;
    wb(1'b1, R_HP_CTRL, 32'h1 << HC_SETUP);
    hp(HC_CANCEL, pa, pb);
    playing <= 1'b0;
  endtask : t_hp
  initial begin
    repeat (6) @(posedge ref_clk);
    reset <= 1'b0;
    @(posedge ref_clk);
    t_reset();
    t_bus();
    t_att();
    t_fmt();
    t_hp();
    give_verdict();
  end
endmodule : tb
